// ==== hdl/scfp_device.sv ====
`timescale 1ns/1ps
`include "scfp_params.svh"

module scfp_device import scfp_pkg::*; #(
    parameter int CNT_W = 8
) (
    input wire logic clk_sys, // system clock, 50 MHz
    input wire logic arst_n, // async reset, active low
    input wire logic sclk, // serial clock from the controller
    input wire logic chip_select_low, // frame select, active low
    input wire logic dataIn, // serial data from the controller
    output logic dataOut, // serial data to the controller
    output logic dataOutEn, // high while the output pin is driven
    input wire logic supplyLow, // undervoltage condition, level
    input wire logic [15:0] diagStatus, // other diagnosis bits from the device
    input wire logic addrUsed, // addressed register exists
    input wire logic [7:0] regRdData, // content of addressed register
    output scfp_cmd_t cmdOut, // decoded command of the last frame, good or bad
    output logic cmdValid, // one-cycle pulse: execute cmdOut
    output logic frameErrorFlag // set by reset and cleared at the first diagnosis load; transmission errors only reach answer bit 10
);

    if (CNT_W != 8) begin : g_bad_cnt_w
        $error("scfp_device: CNT_W must be 8");
    end

    // ----------------------------------------
    // link domain, clocked by the serial clock
    // ----------------------------------------
    scfp_link_t link_reg;
    scfp_link_t link_next;
    scfp_sys_t sys_reg;
    scfp_sys_t sys_next;
    logic firstBit;
    logic frameIdle;
    logic [7:0] bitIdx;

    assign frameIdle = chip_select_low | ~arst_n;

    // shift and count are quiet once select rises, since the serial clock only
    // runs inside frames; the system side reads them only at frame end

    // the serial clock stops between frames, so the counter restarts on the
    // first edge of a frame instead of on select, keeping the last count
    // readable for the system side after the frame
    always_ff @(negedge sclk or posedge frameIdle) begin
        if (frameIdle) begin
            firstBit <= 1'b1;
        end else begin
            firstBit <= 1'b0;
        end
    end

    always_comb begin
        link_next = link_reg;
        link_next.shift = {link_reg.shift[14:0], dataIn};
        if (firstBit) begin
            link_next.count = 8'h01;
        end else if (link_reg.count != `SCFP_CNT_MAX) begin
            link_next.count = link_reg.count + 8'h01;
        end
    end

    always_ff @(negedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            link_reg <= '0;
        end else begin
            link_next_chk: link_reg <= link_next;
        end
    end

    // resp only changes while select is high, so it is static during a frame
    assign bitIdx = firstBit ? 8'h00 : link_reg.count;
    assign dataOut = (bitIdx < 8'h10) ? sys_reg.resp[4'hf - bitIdx[3:0]] : 1'b0;
    // enable follows the pin directly: the synchronised select is two
    // system clocks late and would leave the line floating at frame start
    assign dataOutEn = ~chip_select_low;

    // ----------------------------------------
    // system domain: frame decode and answer
    // ----------------------------------------
    logic frameEnd;
    logic countOk;
    logic diagReq;
    logic useDiag;
    logic useReg;
    logic [15:0] diagWord;

    assign frameEnd = sys_reg.csnSync & ~sys_reg.csnPrev;
    // the count saturates at 8'hff, so frames of 255 bits or more are refused, never wrapped to a good length
    assign countOk = (link_reg.count >= `SCFP_MIN_BITS) && (link_reg.count[2:0] == 3'h0);
    assign diagReq = ~sys_reg.cmd[`SCFP_WR_BIT] & sys_reg.cmd[`SCFP_DIAG_REQ_BIT];

    always_comb begin
        sys_next = sys_reg;
        useDiag = 1'b0;
        useReg = 1'b0;
        diagWord = 16'h0000;
        sys_next.csnMeta = chip_select_low;
        sys_next.csnSync = sys_reg.csnMeta;
        sys_next.csnPrev = sys_reg.csnSync;
        sys_next.decValid = frameEnd;
        sys_next.decErr = ~countOk;
        if (frameEnd) begin
            sys_next.cmd = link_reg.shift;
        end
        sys_next.terFlag = sys_reg.terFlag | (sys_reg.decValid & sys_reg.decErr);
        sys_next.uvFlag = sys_reg.uvFlag | supplyLow;
        sys_next.loadDiag = sys_reg.loadDiag | supplyLow;
        if (sys_reg.decValid) begin
            if (sys_reg.decErr || sys_next.loadDiag || diagReq || !addrUsed) begin
                useDiag = 1'b1;
            end else begin
                useReg = 1'b1;
            end
        // a supply dip reloads the answer at once while deselected, so the
        // first frame after it can never carry a stale register answer
        end else if (sys_next.loadDiag && sys_reg.csnSync) begin
            useDiag = 1'b1;
        end
        diagWord = {1'b0, diagStatus[14:0]};
        diagWord[`SCFP_UVRST_BIT] = sys_next.uvFlag;
        diagWord[`SCFP_TER_BIT] = sys_next.terFlag;
        if (useDiag) begin
            sys_next.resp = diagWord;
            // events of this cycle are already in the word, so clearing loses none
            sys_next.terFlag = 1'b0;
            sys_next.uvFlag = supplyLow;
            sys_next.loadDiag = supplyLow;
        end else if (useReg) begin
            sys_next.resp = {1'b1, sys_reg.cmd[14:8],
                sys_reg.cmd[`SCFP_WR_BIT] ? sys_reg.cmd[7:0] : regRdData};
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sys_reg <= SCFP_SYS_RST;
        end else begin
            sys_reg <= sys_next;
        end
    end

    assign cmdOut = '{write: sys_reg.cmd[`SCFP_WR_BIT], bank: sys_reg.cmd[`SCFP_BANK_BIT],
        addr: sys_reg.cmd[`SCFP_ADDR_HI:`SCFP_ADDR_LO], data: sys_reg.cmd[7:0]};
    // unused addresses still pulse cmdValid; the bank decides what to ignore
    assign cmdValid = sys_reg.decValid & ~sys_reg.decErr & ~diagReq;
    assign frameErrorFlag = sys_reg.terFlag;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence frameClosed;
        !sys_reg.csnSync ##1 sys_reg.csnSync;
    endsequence

    sequence goodDecode;
        sys_reg.decValid && !sys_reg.decErr && !diagReq;
    endsequence

    sequence badClosed;
        frameClosed ##0 !countOk;
    endsequence

    a_resp_stable_frame: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !sys_reg.csnSync && !$past(sys_reg.csnSync) |-> $stable(sys_reg.resp))
        else $error("answer changed during a frame");
    a_error_gives_diag: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frameClosed ##0 !countOk |=> ##1 !sys_reg.resp[15] && sys_reg.resp[10])
        else $error("bad frame length not answered with error diagnosis");
    a_uv_gives_diag: assert property (@(posedge clk_sys) disable iff (!arst_n)
        supplyLow && sys_reg.csnSync && !sys_reg.decValid |=> !sys_reg.resp[15] && sys_reg.resp[13])
        else $error("undervoltage did not force diagnosis");
    a_unused_addr_diag: assert property (@(posedge clk_sys) disable iff (!arst_n)
        goodDecode ##0 !addrUsed |=> !sys_reg.resp[15])
        else $error("unused address not answered with diagnosis");
    a_read_content: assert property (@(posedge clk_sys) disable iff (!arst_n)
        goodDecode ##0 addrUsed && !sys_reg.loadDiag && !supplyLow && !cmdOut.write
        |=> sys_reg.resp[15] && sys_reg.resp[7:0] == $past(regRdData))
        else $error("read content not returned with MSB high");
    a_cmd_executes: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frameClosed ##0 countOk && !(~link_reg.shift[15] & link_reg.shift[0]) |=> cmdValid ##1 !cmdValid)
        else $error("good frame not executed once");
    a_flags_cleared: assert property (@(posedge clk_sys) disable iff (!arst_n)
        sys_reg.decValid && diagReq && !sys_reg.decErr && !supplyLow
        |=> !sys_reg.terFlag && !sys_reg.uvFlag)
        else $error("error flag not cleared after diagnosis read");
    a_out_released: assert property (@(posedge clk_sys) disable iff (!arst_n)
        chip_select_low |-> !dataOutEn)
        else $error("output driven while deselected");
    a_out_driven: assert property (@(negedge sclk) disable iff (!arst_n)
        dataOutEn)
        else $error("output not driven at a shift edge");
    a_diag_msb_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
        sys_reg.decValid && (sys_reg.decErr || diagReq) |=> !sys_reg.resp[15])
        else $error("diagnosis answer sent with MSB high");
    a_write_echo: assert property (@(posedge clk_sys) disable iff (!arst_n)
        goodDecode ##0 addrUsed && !sys_reg.loadDiag && !supplyLow && cmdOut.write
        |=> sys_reg.resp == {1'b1, $past(sys_reg.cmd[14:0])})
        else $error("write answer does not echo the written frame");
    a_error_no_exec: assert property (@(posedge clk_sys) disable iff (!arst_n)
        badClosed |=> !cmdValid ##1 !cmdValid)
        else $error("bad frame executed");
    a_answer_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
        sys_reg.csnSync && !sys_reg.decValid && !sys_reg.loadDiag && !supplyLow |=> $stable(sys_reg.resp))
        else $error("answer changed between frames without a frame end");
    a_link_count: assert property (@(negedge sclk) disable iff (!arst_n)
        !firstBit && link_reg.count < 8'h10 |=> link_reg.count == $past(link_reg.count) + 8'h01)
        else $error("bit counter did not advance on falling edge");

endmodule : scfp_device

// ==== hdl/scfp_params.svh ====
`ifndef SCFP_PARAMS_SVH
`define SCFP_PARAMS_SVH

// ----------------------------------------
// frame layout
// ----------------------------------------
`define SCFP_FRAME_BITS 16
`define SCFP_MIN_BITS 8'h10
`define SCFP_WR_BIT 15
`define SCFP_BANK_BIT 14
`define SCFP_ADDR_HI 13
`define SCFP_ADDR_LO 8
`define SCFP_DIAG_REQ_BIT 0

// ----------------------------------------
// diagnosis word fields, reset values and bit counter limit
// ----------------------------------------
`define SCFP_UVRST_BIT 13
`define SCFP_TER_BIT 10
`define SCFP_RESP_RST 16'h0000
`define SCFP_CNT_MAX 8'hff

`endif

// ==== hdl/scfp_pkg.sv ====
`include "scfp_params.svh"

package scfp_pkg;

    typedef struct packed {
        logic write;
        logic bank;
        logic [5:0] addr;
        logic [7:0] data;
    } scfp_cmd_t;

    typedef struct packed {
        logic [15:0] shift;
        logic [7:0] count;
    } scfp_link_t;

    typedef struct packed {
        logic csnMeta;
        logic csnSync;
        logic csnPrev;
        logic decValid;
        logic decErr;
        logic [15:0] cmd;
        logic [15:0] resp;
        logic loadDiag;
        logic terFlag;
        logic uvFlag;
    } scfp_sys_t;

    localparam scfp_sys_t SCFP_SYS_RST = '{
        csnMeta: 1'b1, csnSync: 1'b1, csnPrev: 1'b1, decValid: 1'b0, decErr: 1'b0,
        cmd: 16'h0000, resp: `SCFP_RESP_RST, loadDiag: 1'b1, terFlag: 1'b1, uvFlag: 1'b1};

endpackage : scfp_pkg

// ==== tb/scfp_ctrl_model.sv ====
`timescale 1ns/1ps
module scfp_ctrl_model (
    output logic sclk, // serial clock, idle low
    output logic chip_select_low, // frame select, active low
    output logic dataIn, // serial data to the device
    input wire logic soPin // resolved device output pin
);
    initial begin
        sclk = 1'b0;
        chip_select_low = 1'b1;
        dataIn = 1'b0;
    end
    // ----------------------------------------
    // one frame of n bits, msb first
    // ----------------------------------------
    // data moves while sclk is high, so a device sampling the wrong edge sees the previous bit
    task automatic xfer(input int n, input logic [31:0] w, output logic [15:0] r);
        int j;
        r = 16'h0000;
        chip_select_low = 1'b0;
        #176;
        for (int i = n - 1; i >= 0; i--) begin
            #24 sclk = 1'b1;
            // the answer is the first 16 bits; a short frame leaves the low bits at 0
            j = n - 1 - i;
            if (j < 16) r[15 - j] = soPin;
            #2 dataIn = w[i]; // command layout given by caller
            #22 sclk = 1'b0; // stable around the falling edge
        end
        #200 chip_select_low = 1'b1;
        dataIn = 1'b0; // line is driven low between frames
        #300;
    endtask : xfer
endmodule : scfp_ctrl_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import scfp_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic supplyLow = 1'b0;
    logic addrUsed = 1'b1;
    logic [15:0] diagStatus = 16'h0000;
    logic [7:0] regRdData = 8'h00;
    logic sclk, chip_select_low, dataIn, dataOut, dataOutEn, cmdValid, frameErrorFlag;
    wire soPin;
    scfp_cmd_t cmdOut;
    scfp_cmd_t lastCmd;
    int n_errors = 0;
    int total_checks = 0;
    int nValid = 0;
    int v0, op, n;
    logic [31:0] seed = 32'h000139ff;
    logic [31:0] t;
    logic [15:0] r, w, expN, msk;

    assign soPin = dataOutEn ? dataOut : 1'bz;
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (cmdValid === 1'b1) begin
            nValid <= nValid + 1;
            lastCmd <= cmdOut;
        end
    end

    scfp_device i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .sclk(sclk),
        .chip_select_low(chip_select_low), .dataIn(dataIn), .dataOut(dataOut),
        .dataOutEn(dataOutEn), .supplyLow(supplyLow), .diagStatus(diagStatus),
        .addrUsed(addrUsed), .regRdData(regRdData), .cmdOut(cmdOut), .cmdValid(cmdValid),
        .frameErrorFlag(frameErrorFlag));
    scfp_ctrl_model i_ctrl (.sclk(sclk), .chip_select_low(chip_select_low), .dataIn(dataIn),
        .soPin(soPin));

    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : lfsr
    function automatic logic [15:0] diagExp(input logic frame_error_flag, input logic uv);
        return {1'b0, diagStatus[14], uv, diagStatus[12:11], frame_error_flag, diagStatus[9:0]};
    endfunction : diagExp
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic stop_test();
        if (n_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test

    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
    // ----------------------------------------
    // main sequence: ops cycle write, read, diag, bad count, unused, undervoltage
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        chk("error flag", {15'h0000, frameErrorFlag}, 16'h0001);
        #2 arst_n = 1'b1;
        t = lfsr();
        diagStatus = t[15:0];
        expN = diagExp(1'b1, 1'b1);
        msk = 16'hffff;
        repeat (3) @(posedge clk_sys);
        for (int k = 0; k < 30; k++) begin
            @(posedge clk_sys);
            #2;
            t = lfsr();
            op = k % 6;
            v0 = nValid;
            addrUsed = (op != 4);
            regRdData = t[31:24];
            w = {op == 0 || op == 5, t[14:1], op == 2};
            n = (op == 3) ? (t[16] ? 20 : 12) : (t[17] ? 24 : 16);
            if (op == 5) begin
                supplyLow = 1'b1;
                repeat (3) @(posedge clk_sys);
                #2 supplyLow = 1'b0;
                repeat (4) @(posedge clk_sys);
                #2;
                expN = diagExp(1'b0, 1'b1);
                msk = 16'hffff;
            end
            // a 12-bit frame only brings back the upper 12 answer bits
            if (n < 16) msk = msk & 16'hfff0;
            i_ctrl.xfer(n, {t[31:16], w}, r);
            chk("answer", r & msk, expN & msk);
            chk("output enable", {15'h0000, dataOutEn}, 16'h0000);
            chk("error flag", {15'h0000, frameErrorFlag}, 16'h0000);
            chk("pulses", 16'(nValid - v0), 16'((op == 2 || op == 3) ? 0 : 1));
            if (op != 2 && op != 3) chk("command", lastCmd, w);
            case (op)
                1: expN = {1'b1, w[14:8], regRdData};
                0, 5: expN = {1'b1, w[14:0]};
                default: expN = diagExp(op == 3, 1'b0); // flags cleared by earlier reads
            endcase
            // read answer bits 14:8, the echoed bank and address, are not compared
            msk = (op == 1) ? 16'h80ff : 16'hffff;
        end
        stop_test();
    end
endmodule : tb_top
